/* pkg/bctl_pkg.sv */
/*
 * bctl_pkg: constants and types for the bus cycle timing controller.
 * Assumes one core clock; shared by the controller and its bench.
 */
`default_nettype none
package bctl_pkg;
   // special function space location and reset image of the control register
   localparam logic [7:0] BUS_TIMING_CONTROL_ADDR  = 8'h9d;
   localparam logic [7:0] BUS_TIMING_CONTROL_RESET = 8'heb;
   // field positions
   localparam int PFQ_EN_BIT   = 7;
   localparam int BC_EN_BIT    = 6;
   localparam int WR_LEN_LSB   = 4;
   localparam int RD_LEN_LSB   = 2;
   localparam int CODE_LEN_LSB = 0;
   // cycle lengths in core clock periods, and the field codes that select 4 and 5
   localparam logic [2:0] LEN_4 = 3'h4;
   localparam logic [2:0] LEN_5 = 3'h5;
   localparam logic [2:0] LEN_6 = 3'h6;
   localparam logic [1:0] LEN_CODE_4 = 2'h0;
   localparam logic [1:0] LEN_CODE_5 = 2'h1;

   typedef enum logic [1:0] {
      BCTL_KIND_FETCH,
      BCTL_KIND_CODE_READ,
      BCTL_KIND_DATA_READ,
      BCTL_KIND_DATA_WRITE
   } bctl_kind_t;

   // one bus request from the core sequencer
   typedef struct packed {
      bctl_kind_t  kind;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bctl_req_t;

   // special function space access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } bctl_sfr_t;
endpackage
`default_nettype wire

/* rtl/bctl_ctrl.sv */
/*
 * bctl_ctrl: bus control register plus the bus cycle sequencer that
 * drives code, read and write strobes with programmable lengths.
 * Assumes the core and the memory module share clk; read data from
 * the bus is synchronised and must be stable two cycles before the end.
 */
// Function
// - software may reprogram cycle lengths at any time through the control register
// - after reset all cycles last six core clock periods
// - one length per strobe type, regardless of the address accessed
// - code strobe length is independent of read and write lengths
// - prefetch queue and branch cache enables are written independently
// - both enables are on after reset
// - code cycles carry sixteen bits, data reads only eight
// - a code fetch may be cut short when prefetch logic drops it
// - equal code and read lengths give identical cycle timing while no prefetch stall or fetch abort occurs
// - code cycles stretch only while the prefetch queue stalls
// - prefetch stalls never stretch data read cycles
// - register sits at 9Dh and resets to EBh
// - bit 7 enables prefetch queue, bit 6 enables branch cache
// - write length bits 5:4 select 4, 5 or 6 periods
`default_nettype none
module bctl_ctrl (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire bctl_pkg::bctl_sfr_t special_function_space,
   output logic [7:0]               sfr_rdata,
   input  wire logic                req_valid,
   input  wire bctl_pkg::bctl_req_t req,
   input  wire logic                fetch_abort,
   input  wire logic                pfq_stall,
   output logic                     busy,
   output logic                     done,
   output logic [15:0]              rdata,
   output logic                     prefetch_queue_enable,
   output logic                     branch_cache_enable,
   output logic                     code_read_strobe,
   output logic                     data_read_strobe,
   output logic                     data_write_strobe,
   output logic [15:0]              bus_addr,
   output logic [7:0]               ad_o,
   output logic                     ad_oe,
   input  wire logic [15:0]         ad_i
);
   logic [7:0]           ctl_r;
   logic [7:0]           sfr_rdata_r;
   logic                 busy_r;
   logic                 done_r;
   logic [15:0]          rdata_r;
   logic [2:0]           len_r;
   logic [2:0]           cnt_r;
   bctl_pkg::bctl_kind_t kind_r;
   logic                 code_r, rd_r, wr_r;
   logic [15:0]          addr_r;
   logic [7:0]           ad_o_r;
   logic                 ad_oe_r;
   logic [15:0]          din_s1_r, din_s2_r;
   logic                 sfr_hit;
   logic                 start;
   logic                 finish;
   logic                 is_code;
   logic [2:0]           len_nxt;

   // decode a two-bit length field into core clock periods
   function automatic logic [2:0] len_of(input logic [1:0] code);
      if (code == bctl_pkg::LEN_CODE_4) begin
         return bctl_pkg::LEN_4;
      end else if (code == bctl_pkg::LEN_CODE_5) begin
         return bctl_pkg::LEN_5;
      end else begin
         return bctl_pkg::LEN_6;
      end
   endfunction

   assign sfr_hit = special_function_space.addr == bctl_pkg::BUS_TIMING_CONTROL_ADDR;
   assign start   = req_valid && !busy_r;
   assign is_code = kind_r == bctl_pkg::BCTL_KIND_FETCH ||
                    kind_r == bctl_pkg::BCTL_KIND_CODE_READ;
   // end at the programmed count, or early for a dropped fetch
   assign finish  = busy_r && ((cnt_r == len_r && !(is_code && pfq_stall)) ||
                    (kind_r == bctl_pkg::BCTL_KIND_FETCH && fetch_abort));

   // length chosen only by strobe type, never by address
   always_comb begin
      unique case (req.kind)
         bctl_pkg::BCTL_KIND_FETCH,
         bctl_pkg::BCTL_KIND_CODE_READ:
            len_nxt = len_of(ctl_r[bctl_pkg::CODE_LEN_LSB +: 2]);
         bctl_pkg::BCTL_KIND_DATA_READ:
            len_nxt = len_of(ctl_r[bctl_pkg::RD_LEN_LSB +: 2]);
         bctl_pkg::BCTL_KIND_DATA_WRITE:
            len_nxt = len_of(ctl_r[bctl_pkg::WR_LEN_LSB +: 2]);
      endcase
   end

   // control register, writable at any time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= bctl_pkg::BUS_TIMING_CONTROL_RESET;
      end else if (special_function_space.wr && sfr_hit) begin
         ctl_r <= special_function_space.wdata;
      end
   end

   // register read-back, zero when another address is read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata_r <= 8'h00;
      end else if (special_function_space.rd && sfr_hit) begin
         sfr_rdata_r <= ctl_r;
      end else begin
         sfr_rdata_r <= 8'h00;
      end
   end

   // two-stage capture of bus data from outside
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_s1_r <= 16'h0000;
         din_s2_r <= 16'h0000;
      end else begin
         din_s1_r <= ad_i;
         din_s2_r <= din_s1_r;
      end
   end

   // cycle sequencer: count periods, stall holds code cycles only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         cnt_r  <= 3'h0;
         len_r  <= bctl_pkg::LEN_6;
         kind_r <= bctl_pkg::BCTL_KIND_FETCH;
         addr_r <= 16'h0000;
      end else if (start) begin
         busy_r <= 1'b1;
         cnt_r  <= 3'h1;
         len_r  <= len_nxt;
         kind_r <= req.kind;
         addr_r <= req.addr;
      end else if (finish) begin
         busy_r <= 1'b0;
         cnt_r  <= 3'h0;
      end else if (busy_r && !(is_code && pfq_stall)) begin
         cnt_r  <= cnt_r + 3'h1;
      end
   end

   // strobes and write data drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_r  <= 1'b0;
         rd_r    <= 1'b0;
         wr_r    <= 1'b0;
         ad_o_r  <= 8'h00;
         ad_oe_r <= 1'b0;
      end else if (start) begin
         code_r  <= req.kind == bctl_pkg::BCTL_KIND_FETCH ||
                    req.kind == bctl_pkg::BCTL_KIND_CODE_READ;
         rd_r    <= req.kind == bctl_pkg::BCTL_KIND_DATA_READ;
         wr_r    <= req.kind == bctl_pkg::BCTL_KIND_DATA_WRITE;
         ad_o_r  <= req.wdata;
         ad_oe_r <= req.kind == bctl_pkg::BCTL_KIND_DATA_WRITE;
      end else if (finish) begin
         code_r  <= 1'b0;
         rd_r    <= 1'b0;
         wr_r    <= 1'b0;
         ad_oe_r <= 1'b0;
      end
   end

   // completion pulse and returned data width
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r  <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         done_r <= finish;
         if (finish && is_code) begin
            rdata_r <= din_s2_r;
         end else if (finish && kind_r == bctl_pkg::BCTL_KIND_DATA_READ) begin
            rdata_r <= {8'h00, din_s2_r[7:0]};
         end
      end
   end

   assign sfr_rdata             = sfr_rdata_r;
   assign busy                  = busy_r;
   assign done                  = done_r;
   assign rdata                 = rdata_r;
   assign prefetch_queue_enable = ctl_r[bctl_pkg::PFQ_EN_BIT];
   assign branch_cache_enable   = ctl_r[bctl_pkg::BC_EN_BIT];
   assign code_read_strobe      = code_r;
   assign data_read_strobe      = rd_r;
   assign data_write_strobe     = wr_r;
   assign bus_addr              = addr_r;
   assign ad_o                  = ad_o_r;
   assign ad_oe                 = ad_oe_r;

   // helper: consecutive strobe-high cycles
   logic [3:0] hi_cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt_r <= 4'h0;
      end else if (code_r || rd_r || wr_r) begin
         hi_cnt_r <= hi_cnt_r + 4'h1;
      end else begin
         hi_cnt_r <= 4'h0;
      end
   end

   sequence s_ctl_write;
      special_function_space.wr && sfr_hit;
   endsequence

   sequence s_data_read_start;
      start && req.kind == bctl_pkg::BCTL_KIND_DATA_READ;
   endsequence

   a_ctl_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
      s_ctl_write |=> ctl_r == $past(special_function_space.wdata))
      else $error("control write not stored");
   a_enable_bits: assert property (@(posedge clk) disable iff (!rst_n)
      s_ctl_write |=> prefetch_queue_enable == $past(special_function_space.wdata[7]) &&
                      branch_cache_enable == $past(special_function_space.wdata[6]))
      else $error("enable bits do not follow write");
   a_readback_value: assert property (@(posedge clk) disable iff (!rst_n)
      special_function_space.rd && sfr_hit && !special_function_space.wr |=> sfr_rdata == $past(ctl_r))
      else $error("register read-back wrong");
   a_read_length: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(rd_r) |-> hi_cnt_r == {1'b0, len_r})
      else $error("data read strobe length wrong");
   a_write_length: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(wr_r) |-> hi_cnt_r == {1'b0, len_r})
      else $error("write strobe length wrong");
   a_read_rises: assert property (@(posedge clk) disable iff (!rst_n)
      s_data_read_start ##1 1'b1 |-> rd_r && !code_r && !wr_r)
      else $error("data read strobe not raised");
   a_code_stall_hold: assert property (@(posedge clk) disable iff (!rst_n)
      busy_r && is_code && pfq_stall && !fetch_abort |=> code_r && cnt_r == $past(cnt_r))
      else $error("stall did not hold code cycle");
   a_fetch_abort_ends: assert property (@(posedge clk) disable iff (!rst_n)
      busy_r && kind_r == bctl_pkg::BCTL_KIND_FETCH && fetch_abort |=> !code_r && done_r)
      else $error("aborted fetch not ended");
   a_byte_read_width: assert property (@(posedge clk) disable iff (!rst_n)
      done_r && $past(kind_r) == bctl_pkg::BCTL_KIND_DATA_READ |-> rdata[15:8] == 8'h00)
      else $error("data read wider than a byte");
   a_default_len: assert property (@(posedge clk) disable iff (!rst_n)
      start && ctl_r[5:0] == bctl_pkg::BUS_TIMING_CONTROL_RESET[5:0] |=> len_r == bctl_pkg::LEN_6)
      else $error("reset length is not six");
endmodule
`default_nettype wire

/* testbench/bctl_mem_model.sv */
/*
 * bctl_mem_model: memory module on the far side of the bus cycle controller.
 * Assumes the controller holds bus_addr steady for the whole strobe.
 */
`default_nettype none
module bctl_mem_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        code_read_strobe,
   input  wire logic        data_read_strobe,
   input  wire logic [15:0] bus_addr,
   output logic [15:0]      ad_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last_r;
   // remember the bus level so a released bus can show its inverse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) last_r <= 16'h0000;
      else last_r <= ad_i;
   end
   // word from the address while a read strobe is up, else a changing pattern
   assign ad_i = (code_read_strobe || data_read_strobe) ?
                 {~bus_addr[7:0], bus_addr[15:8]} : ~last_r;
endmodule
`default_nettype wire

/* testbench/bus_cycle_timing_control_tb.sv */
/*
 * bus_cycle_timing_control_tb: register and bus cycle tests of bctl_ctrl.
 * Assumes the memory model answers every read strobe at once.
 */
`default_nettype none
module bus_cycle_timing_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, fetch_abort = 1'b0, pfq_stall = 1'b0;
   bctl_pkg::bctl_sfr_t special_function_space = '0;
   bctl_pkg::bctl_req_t req = '0;
   logic [7:0] sfr_rdata, ad_o;
   logic [15:0] rdata, bus_addr, ad_i;
   logic busy, done, pqe, bce, crs, drs, dws, ad_oe;
   int fails = 0, cmp_count = 0;
   always #2 clk = ~clk; // 250 MHz core clock
   bctl_ctrl dut_u (.clk(clk), .rst_n(rst_n), .special_function_space(special_function_space), .sfr_rdata(sfr_rdata),
      .req_valid(req_valid), .req(req), .fetch_abort(fetch_abort), .pfq_stall(pfq_stall),
      .busy(busy), .done(done), .rdata(rdata), .prefetch_queue_enable(pqe),
      .branch_cache_enable(bce), .code_read_strobe(crs), .data_read_strobe(drs),
      .data_write_strobe(dws), .bus_addr(bus_addr), .ad_o(ad_o), .ad_oe(ad_oe), .ad_i(ad_i));
   bctl_mem_model mem_u (.clk(clk), .rst_n(rst_n), .code_read_strobe(crs),
      .data_read_strobe(drs), .bus_addr(bus_addr), .ad_i(ad_i));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one register access, read answer lands after the taking edge
   task automatic sfr_op(input logic [7:0] a, input logic wr, input logic [7:0] d);
      // let an edge pass so the release of the last access is not overwritten
      @(posedge clk);
      #1;
      special_function_space = '{addr: a, wr: wr, rd: ~wr, wdata: d};
      @(posedge clk);
      #1 special_function_space = '0;
   endtask
   function automatic int len_of(input logic [1:0] c);
      return (c == 2'h0) ? 4 : (c == 2'h1) ? 5 : 6;
   endfunction
   // one bus cycle; counts strobe cycles and checks the data it carried
   task automatic bus_op(input bctl_pkg::bctl_kind_t k, input logic [15:0] a,
                         input bit st, input bit ab, input int exp_n);
      int n;
      int i;
      logic s;
      n = 0;
      req_valid = 1'b1;
      req = '{kind: k, addr: a, wdata: a[7:0] ^ 8'ha5};
      @(posedge clk);
      #1 req_valid = 1'b0;
      for (i = 0; i < 30 && done !== 1'b1; i++) begin
         s = (k == bctl_pkg::BCTL_KIND_DATA_READ) ? drs :
             (k == bctl_pkg::BCTL_KIND_DATA_WRITE) ? dws : crs;
         if (s === 1'b1) n++;
         if (i == 0) chk("busy", 16'h0001, {15'h0000, busy});
         if (k == bctl_pkg::BCTL_KIND_DATA_WRITE && n == 1)
            chk("write data", {7'h00, 1'b1, a[7:0] ^ 8'ha5}, {7'h00, ad_oe, ad_o});
         pfq_stall = st && n > 0 && n < 3;
         fetch_abort = ab && n == 2;
         @(posedge clk);
         #1;
      end
      pfq_stall = 1'b0;
      fetch_abort = 1'b0;
      chk("strobe cycles", exp_n[15:0], n[15:0]);
      chk("busy after done", 16'h0000, {15'h0000, busy});
      if (k == bctl_pkg::BCTL_KIND_DATA_READ)
         chk("byte read", {8'h00, a[15:8]}, rdata);
      else if (k != bctl_pkg::BCTL_KIND_DATA_WRITE && !ab)
         chk("code word", {~a[7:0], a[15:8]}, rdata);
      @(posedge clk);
      #1;
      chk("done pulse", 16'h0000, {15'h0000, done});
   endtask
   initial begin
      logic [1:0] c;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("enables", 16'h0003, {14'h0, pqe, bce});
      sfr_op(8'h9d, 1'b0, 8'h00);
      chk("reset value", 16'h00eb, {8'h00, sfr_rdata});
      sfr_op(8'h9c, 1'b0, 8'h00);
      chk("unmapped read", 16'h0000, {8'h00, sfr_rdata});
      bus_op(bctl_pkg::BCTL_KIND_DATA_WRITE, 16'h8001, 1'b0, 1'b0, 6);
      bus_op(bctl_pkg::BCTL_KIND_CODE_READ, 16'h1234, 1'b0, 1'b0, 6);
      bus_op(bctl_pkg::BCTL_KIND_CODE_READ, 16'h4321, 1'b1, 1'b0, 8);
      bus_op(bctl_pkg::BCTL_KIND_DATA_READ, 16'hf00d, 1'b1, 1'b0, 6);
      bus_op(bctl_pkg::BCTL_KIND_FETCH, 16'h0042, 1'b0, 1'b1, 2);
      $display("test reset and stall done");
      // every code in every field, with the three fields kept different
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         sfr_op(8'h9d, 1'b1, {c[0], c[1], c, c + 2'h1, c + 2'h2});
         chk("enables", {14'h0, c[0], c[1]}, {14'h0, pqe, bce});
         bus_op(bctl_pkg::BCTL_KIND_DATA_WRITE, {c, 14'h0011}, 1'b0, 1'b0, len_of(c));
         bus_op(bctl_pkg::BCTL_KIND_DATA_READ, {c, 14'h2a5c}, 1'b0, 1'b0, len_of(c + 2'h1));
         bus_op(bctl_pkg::BCTL_KIND_FETCH, {~c, 14'h0777}, 1'b0, 1'b0, len_of(c + 2'h2));
      end
      $display("test length fields done");
      // a second reset in mid-run brings back long cycles and both enables
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("enables after reset", 16'h0003, {14'h0, pqe, bce});
      sfr_op(8'h9d, 1'b0, 8'h00);
      chk("value after reset", 16'h00eb, {8'h00, sfr_rdata});
      bus_op(bctl_pkg::BCTL_KIND_DATA_READ, 16'h5aa5, 1'b0, 1'b0, 6);
      bus_op(bctl_pkg::BCTL_KIND_FETCH, 16'h3c96, 1'b0, 1'b0, 6);
      $display("test second reset done");
      test_done();
   end
   // watchdog well beyond the expected run length
   initial begin
      #20000;
      fails++;
      test_done();
   end
endmodule
`default_nettype wire
